// ### ebiu_pkg.sv
// Shared constants and state types for the external bus interface unit.
package ebiu_pkg;

    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int BLOCK_W = 128;
    localparam int TAG_W = 20;
    localparam int SYNC_W = 46;

    // Transfer kinds requested by the core.
    localparam logic [1:0] KIND_SINGLE = 2'h0;
    localparam logic [1:0] KIND_WORD = 2'h1;
    localparam logic [1:0] KIND_LINE = 2'h2;
    localparam logic [1:0] KIND_RUN = 2'h3;

    // Beat counts of the single, word and line transfer kinds.
    localparam logic [3:0] BEATS_SINGLE = 4'h1;
    localparam logic [3:0] BEATS_WORD = 4'h2;
    localparam logic [3:0] BEATS_LINE = 4'h8;

    // Reset values of the pin-facing flip-flops.
    localparam logic RST_STROBE_N = 1'b1;
    localparam logic RST_RW = 1'b1;
    localparam logic RST_OE = 1'b1;

    // Reset value of the synchronised pin vector: active-low pins idle high.
    localparam logic [SYNC_W-1:0] SYNC_RST = {7'h7f, 39'h00_0000_0000};

    typedef enum logic [2:0] {
        B_IDLE = 3'h0,
        B_START = 3'h1,
        B_WAIT = 3'h3,
        B_TURN = 3'h2,
        B_HOLD_ENTER = 3'h6,
        B_HOLD = 3'h7,
        B_HOLD_EXIT = 3'h5
    } bus_state_e;

    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_FLUSH = 2'h1,
        H_FILL = 2'h3,
        H_SERVE = 2'h2
    } hold_state_e;

endpackage

// ### pin_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// ### external_bus_interface_unit.sv
// External bus interface unit: core bus cycles, bursts, waits, hold and external DRAM access.
`timescale 1ns/10ps

module external_bus_interface_unit #(
    parameter int DRAM_IDX_W = 16
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    // Core request port.
    input wire logic REQ_VALID_I,
    input wire logic [23:0] REQ_ADDR_I,
    input wire logic [1:0] REQ_KIND_I,
    input wire logic REQ_WRITE_I,
    input wire logic REQ_IO_I,
    input wire logic REQ_FETCH_I,
    input wire logic [1:0] REQ_LANES_I,
    input wire logic [31:0] REQ_WDATA_I,
    output logic REQ_READY_O,
    output logic RD_VALID_O,
    output logic [15:0] RD_DATA_O,
    output logic DONE_O,
    // External bus pins.
    input wire logic [22:0] ADDR_I,
    output logic [22:0] ADDR_O,
    output logic ADDR_OE_O,
    input wire logic [15:0] DATA_I,
    output logic [15:0] DATA_O,
    output logic DATA_OE_O,
    input wire logic SPACE_SELECT_I,
    output logic SPACE_SELECT_O,
    input wire logic UPPER_BYTE_STROBE_N_I,
    output logic UPPER_BYTE_STROBE_N_O,
    input wire logic LOWER_BYTE_STROBE_N_I,
    output logic LOWER_BYTE_STROBE_N_O,
    input wire logic RW_I,
    output logic RW_O,
    output logic CYCLE_TYPE_O,
    output logic CYCLE_START_STROBE_N_O,
    output logic BURST_N_O,
    output logic CTRL_OE_O,
    input wire logic CYCLE_COMPLETE_N_I,
    output logic CYCLE_COMPLETE_N_O,
    output logic CYCLE_COMPLETE_OE_O,
    input wire logic HOLD_REQUEST_N_I,
    output logic HOLD_ACKNOWLEDGE_N_O,
    input wire logic CHIP_SELECT_N_I,
    // On-chip DRAM block port.
    output logic DRAM_REQ_O,
    output logic DRAM_WE_O,
    output logic [DRAM_IDX_W-1:0] DRAM_ADDR_O,
    output logic [127:0] DRAM_WDATA_O,
    input wire logic [127:0] DRAM_RDATA_I,
    input wire logic DRAM_ACK_I
);
    initial begin
        if (DRAM_IDX_W < 1 || DRAM_IDX_W > ebiu_pkg::TAG_W) begin
            $error("DRAM_IDX_W must lie between 1 and the block tag width");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [22:0] beat_addr(input logic [22:0] base, input logic [3:0] beat);
        return {base[22:3], 3'(base[2:0] + beat[2:0])};
    endfunction

    function automatic logic [3:0] beats_for(input logic [1:0] kind, input logic [2:0] low);
        case (kind)
            ebiu_pkg::KIND_SINGLE: return ebiu_pkg::BEATS_SINGLE;
            ebiu_pkg::KIND_WORD: return ebiu_pkg::BEATS_WORD;
            ebiu_pkg::KIND_LINE: return ebiu_pkg::BEATS_LINE;
            default: return 4'(ebiu_pkg::BEATS_LINE - {1'b0, low});
        endcase
    endfunction

    // Halfword 0 sits at the lowest address, which is the most significant one.
    function automatic logic [6:0] hw_pos(input logic [2:0] idx);
        return {~idx, 4'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    logic [45:0] sync_q;
    logic hold_req_n_s, complete_n_s, cs_n_s, rw_s, sid_s, ub_n_s, lb_n_s;
    logic [22:0] addr_s;
    logic [15:0] data_s;

    pin_sync #(.W(ebiu_pkg::SYNC_W), .RST_VAL(ebiu_pkg::SYNC_RST)) u_sync (
        .clk_i(REF_CLK_I),
        .rst_i(RESET_I),
        .d_i({HOLD_REQUEST_N_I, CYCLE_COMPLETE_N_I, CHIP_SELECT_N_I, RW_I, UPPER_BYTE_STROBE_N_I,
              LOWER_BYTE_STROBE_N_I, SPACE_SELECT_I, ADDR_I, DATA_I}),
        .q_o(sync_q)
    );

    assign {hold_req_n_s, complete_n_s, cs_n_s, rw_s, ub_n_s, lb_n_s, sid_s, addr_s, data_s} = sync_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Core-side bus cycles.

    ebiu_pkg::bus_state_e state_q;
    ebiu_pkg::hold_state_e h_state_q;
    logic [22:0] base_q;
    logic [3:0] beat_q, total_q;
    logic write_q, prev_read_q, dirty_q;
    logic [1:0] kind_q, lanes_q;
    logic [31:0] wdata_q;
    logic take_req, last_beat;
    logic [3:0] next_beat;

    assign take_req = state_q == ebiu_pkg::B_IDLE && REQ_READY_O && REQ_VALID_I && hold_req_n_s;
    assign last_beat = beat_q == 4'(total_q - 4'h1);
    assign next_beat = 4'(beat_q + 4'h1);

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            state_q <= ebiu_pkg::B_IDLE;
        end else begin
            case (state_q)
                ebiu_pkg::B_IDLE: begin
                    if (!hold_req_n_s) begin
                        state_q <= ebiu_pkg::B_HOLD_ENTER;
                    end else if (take_req && REQ_WRITE_I && prev_read_q) begin
                        state_q <= ebiu_pkg::B_TURN;
                    end else if (take_req) begin
                        state_q <= ebiu_pkg::B_START;
                    end
                end
                ebiu_pkg::B_TURN: state_q <= ebiu_pkg::B_START;
                ebiu_pkg::B_START: state_q <= ebiu_pkg::B_WAIT;
                ebiu_pkg::B_WAIT: begin
                    if (!complete_n_s) begin
                        state_q <= last_beat ? ebiu_pkg::B_IDLE : ebiu_pkg::B_START;
                    end
                end
                ebiu_pkg::B_HOLD_ENTER: state_q <= ebiu_pkg::B_HOLD;
                ebiu_pkg::B_HOLD: begin
                    if (hold_req_n_s && cs_n_s && !dirty_q && h_state_q == ebiu_pkg::H_IDLE) begin
                        state_q <= ebiu_pkg::B_HOLD_EXIT;
                    end
                end
                default: state_q <= ebiu_pkg::B_IDLE;
            endcase
        end
    end

    // Transfer bookkeeping.
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            base_q <= '0;
            beat_q <= '0;
            total_q <= ebiu_pkg::BEATS_SINGLE;
            write_q <= 1'b0;
            kind_q <= ebiu_pkg::KIND_SINGLE;
            lanes_q <= 2'h3;
            wdata_q <= '0;
            prev_read_q <= 1'b0;
        end else begin
            if (take_req) begin
                base_q <= REQ_ADDR_I[23:1];
                beat_q <= 4'h0;
                total_q <= beats_for(REQ_KIND_I, REQ_ADDR_I[3:1]);
                write_q <= REQ_WRITE_I;
                kind_q <= REQ_KIND_I;
                lanes_q <= REQ_KIND_I == ebiu_pkg::KIND_SINGLE ? REQ_LANES_I : 2'h3;
                wdata_q <= REQ_WDATA_I;
            end else if (state_q == ebiu_pkg::B_WAIT && !complete_n_s && !last_beat) begin
                beat_q <= next_beat;
            end
            // A quiet idle cycle already gives the bus its turnaround.
            if (state_q == ebiu_pkg::B_WAIT && !complete_n_s && last_beat) begin
                prev_read_q <= !write_q;
            end else if (state_q == ebiu_pkg::B_IDLE && !take_req) begin
                prev_read_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle pins driven for the core.

    logic begin_cycle;
    logic [3:0] cyc_beat;
    logic [22:0] cyc_addr;
    logic [15:0] cyc_data;

    assign begin_cycle = state_q == ebiu_pkg::B_TURN || (state_q == ebiu_pkg::B_IDLE && take_req && !
                         (REQ_WRITE_I && prev_read_q)) || (state_q == ebiu_pkg::B_WAIT && !complete_n_s
                         && !last_beat);
    assign cyc_beat = state_q == ebiu_pkg::B_WAIT ? next_beat : 4'h0;

    always_comb begin
        cyc_addr = beat_addr(base_q, cyc_beat);
        cyc_data = wdata_q[15:0];
        if (state_q == ebiu_pkg::B_IDLE) begin
            cyc_addr = REQ_ADDR_I[23:1];
            cyc_data = REQ_KIND_I == ebiu_pkg::KIND_WORD ? REQ_WDATA_I[31:16] : REQ_WDATA_I[15:0];
        end else if (kind_q == ebiu_pkg::KIND_WORD && cyc_beat == 4'h0) begin
            cyc_data = wdata_q[31:16];
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            ADDR_O <= '0;
            SPACE_SELECT_O <= 1'b0;
            RW_O <= ebiu_pkg::RST_RW;
            CYCLE_TYPE_O <= 1'b1;
            UPPER_BYTE_STROBE_N_O <= ebiu_pkg::RST_STROBE_N;
            LOWER_BYTE_STROBE_N_O <= ebiu_pkg::RST_STROBE_N;
            CYCLE_START_STROBE_N_O <= ebiu_pkg::RST_STROBE_N;
            BURST_N_O <= ebiu_pkg::RST_STROBE_N;
        end else begin
            CYCLE_START_STROBE_N_O <= !begin_cycle;
            if (state_q == ebiu_pkg::B_IDLE && take_req) begin
                SPACE_SELECT_O <= REQ_IO_I;
                CYCLE_TYPE_O <= !REQ_FETCH_I;
                RW_O <= !REQ_WRITE_I;
                // Reads lower both strobes; single writes lower only written lanes.
                UPPER_BYTE_STROBE_N_O <= REQ_WRITE_I && REQ_KIND_I == ebiu_pkg::KIND_SINGLE && !REQ_LANES_I[1];
                LOWER_BYTE_STROBE_N_O <= REQ_WRITE_I && REQ_KIND_I == ebiu_pkg::KIND_SINGLE && !REQ_LANES_I[0];
            end
            if (begin_cycle) begin
                ADDR_O <= cyc_addr;
                BURST_N_O <= state_q == ebiu_pkg::B_IDLE ? REQ_KIND_I == ebiu_pkg::KIND_SINGLE
                             : (total_q == 4'h1 || cyc_beat == 4'(total_q - 4'h1));
            end else if (state_q == ebiu_pkg::B_WAIT && !complete_n_s && last_beat) begin
                BURST_N_O <= 1'b1;
            end
        end
    end

    // Output enables and core-facing answers.
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            ADDR_OE_O <= ebiu_pkg::RST_OE;
            CTRL_OE_O <= ebiu_pkg::RST_OE;
            HOLD_ACKNOWLEDGE_N_O <= 1'b1;
            REQ_READY_O <= 1'b0;
            RD_VALID_O <= 1'b0;
            RD_DATA_O <= '0;
            DONE_O <= 1'b0;
        end else begin
            if (state_q == ebiu_pkg::B_IDLE && !hold_req_n_s) begin
                ADDR_OE_O <= 1'b0;
                CTRL_OE_O <= 1'b0;
            end else if (state_q == ebiu_pkg::B_HOLD_EXIT) begin
                ADDR_OE_O <= 1'b1;
                CTRL_OE_O <= 1'b1;
            end
            if (state_q == ebiu_pkg::B_HOLD_ENTER) begin
                HOLD_ACKNOWLEDGE_N_O <= 1'b0;
            end else if (state_q == ebiu_pkg::B_HOLD_EXIT) begin
                HOLD_ACKNOWLEDGE_N_O <= 1'b1;
            end
            REQ_READY_O <= state_q == ebiu_pkg::B_IDLE && !take_req && hold_req_n_s;
            RD_VALID_O <= state_q == ebiu_pkg::B_WAIT && !complete_n_s && !write_q;
            if (state_q == ebiu_pkg::B_WAIT && !complete_n_s) begin
                RD_DATA_O <= {lanes_q[1] ? data_s[15:8] : 8'h00, lanes_q[0] ? data_s[7:0] : 8'h00};
            end
            DONE_O <= state_q == ebiu_pkg::B_WAIT && !complete_n_s && last_beat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External master access to on-chip DRAM through the block buffer.

    localparam int TAG_W_L = ebiu_pkg::TAG_W;
    logic [127:0] blk_q;
    logic [TAG_W_L-1:0] tag_q, acc_tag;
    logic blk_valid_q, cs_prev_q, acc_rw_q, acc_ub_n_q, acc_lb_n_q;
    logic [22:0] acc_addr_q;
    logic take_acc, hit, serve;
    logic [6:0] pos;

    // A fresh access is a falling select or a new address under a held select.
    assign take_acc = state_q == ebiu_pkg::B_HOLD && h_state_q == ebiu_pkg::H_IDLE && !cs_n_s && !sid_s
                      && (cs_prev_q || addr_s != acc_addr_q);
    assign acc_tag = take_acc ? addr_s[22:3] : acc_addr_q[22:3];
    assign hit = blk_valid_q && tag_q == acc_tag;
    assign serve = (take_acc && hit) || h_state_q == ebiu_pkg::H_SERVE;
    assign pos = hw_pos(take_acc ? addr_s[2:0] : acc_addr_q[2:0]);

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            h_state_q <= ebiu_pkg::H_IDLE;
        end else begin
            case (h_state_q)
                ebiu_pkg::H_IDLE: begin
                    if (take_acc && !hit) begin
                        h_state_q <= dirty_q ? ebiu_pkg::H_FLUSH : ebiu_pkg::H_FILL;
                    end else if (state_q == ebiu_pkg::B_HOLD && hold_req_n_s && cs_n_s && dirty_q) begin
                        h_state_q <= ebiu_pkg::H_FLUSH;
                    end
                end
                ebiu_pkg::H_FLUSH: begin
                    if (DRAM_ACK_I) begin
                        h_state_q <= cs_n_s ? ebiu_pkg::H_IDLE : ebiu_pkg::H_FILL;
                    end
                end
                ebiu_pkg::H_FILL: begin
                    if (DRAM_ACK_I) begin
                        h_state_q <= ebiu_pkg::H_SERVE;
                    end
                end
                default: h_state_q <= ebiu_pkg::H_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            blk_q <= '0;
            tag_q <= '0;
            blk_valid_q <= 1'b0;
            dirty_q <= 1'b0;
            cs_prev_q <= 1'b1;
            acc_addr_q <= '0;
            acc_rw_q <= 1'b1;
            acc_ub_n_q <= 1'b1;
            acc_lb_n_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_n_s;
            if (take_acc) begin
                acc_addr_q <= addr_s;
                acc_rw_q <= rw_s;
                acc_ub_n_q <= ub_n_s;
                acc_lb_n_q <= lb_n_s;
            end
            if (h_state_q == ebiu_pkg::H_FLUSH && DRAM_ACK_I) begin
                dirty_q <= 1'b0;
            end
            if (h_state_q == ebiu_pkg::H_FILL && DRAM_ACK_I) begin
                blk_q <= DRAM_RDATA_I;
                tag_q <= acc_addr_q[22:3];
                blk_valid_q <= 1'b1;
            end else if (serve && !(take_acc ? rw_s : acc_rw_q)) begin
                // Only lanes whose strobe is low are merged.
                if (!(take_acc ? ub_n_s : acc_ub_n_q)) begin
                    blk_q[7'(pos + 7'h08) +: 8] <= data_s[15:8];
                end
                if (!(take_acc ? lb_n_s : acc_lb_n_q)) begin
                    blk_q[pos +: 8] <= data_s[7:0];
                end
                dirty_q <= 1'b1;
            end
            // The core may change DRAM after hold, so the copy is dropped.
            if (state_q == ebiu_pkg::B_HOLD_EXIT) begin
                blk_valid_q <= 1'b0;
            end
        end
    end

    // Data pins, hold-side completion pins and DRAM port.
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            DATA_O <= '0;
            DATA_OE_O <= 1'b0;
            CYCLE_COMPLETE_N_O <= 1'b1;
            CYCLE_COMPLETE_OE_O <= 1'b0;
            DRAM_REQ_O <= 1'b0;
            DRAM_WE_O <= 1'b0;
            DRAM_ADDR_O <= '0;
            DRAM_WDATA_O <= '0;
        end else begin
            if (state_q == ebiu_pkg::B_HOLD) begin
                DATA_OE_O <= !cs_n_s && rw_s;
                if (serve) begin
                    DATA_O <= blk_q[pos +: 16];
                end
            end else begin
                if (begin_cycle) begin
                    DATA_O <= cyc_data;
                end
                DATA_OE_O <= begin_cycle ? (state_q == ebiu_pkg::B_IDLE ? REQ_WRITE_I : write_q)
                             : (DATA_OE_O && !(state_q == ebiu_pkg::B_WAIT && !complete_n_s && last_beat));
            end
            CYCLE_COMPLETE_OE_O <= state_q == ebiu_pkg::B_HOLD && !cs_n_s;
            CYCLE_COMPLETE_N_O <= !serve;
            DRAM_REQ_O <= (h_state_q == ebiu_pkg::H_IDLE && state_q == ebiu_pkg::B_HOLD
                          && ((take_acc && !hit) || (hold_req_n_s && cs_n_s && dirty_q)))
                          || ((h_state_q == ebiu_pkg::H_FLUSH || h_state_q == ebiu_pkg::H_FILL)
                          && !DRAM_ACK_I) || (h_state_q == ebiu_pkg::H_FLUSH && DRAM_ACK_I && !cs_n_s);
            if (h_state_q == ebiu_pkg::H_IDLE) begin
                DRAM_WE_O <= dirty_q;
                DRAM_ADDR_O <= DRAM_IDX_W'(dirty_q ? tag_q : acc_tag);
                DRAM_WDATA_O <= blk_q;
            end else if (h_state_q == ebiu_pkg::H_FLUSH && DRAM_ACK_I) begin
                DRAM_WE_O <= 1'b0;
                DRAM_ADDR_O <= DRAM_IDX_W'(acc_addr_q[22:3]);
            end
        end
    end
endmodule

// ### ebiu_sva.sv
// Port-level assertions for the external bus interface unit.
`timescale 1ns/10ps
module ebiu_sva (
    input wire logic REF_CLK_I,
    input wire logic RESET_I,
    input wire logic CYCLE_COMPLETE_N_I,
    input wire logic CYCLE_START_STROBE_N_O,
    input wire logic RW_O,
    input wire logic UPPER_BYTE_STROBE_N_O,
    input wire logic LOWER_BYTE_STROBE_N_O,
    input wire logic BURST_N_O,
    input wire logic CTRL_OE_O,
    input wire logic ADDR_OE_O,
    input wire logic HOLD_ACKNOWLEDGE_N_O,
    input wire logic CYCLE_COMPLETE_N_O,
    input wire logic CYCLE_COMPLETE_OE_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RESET_I);
    ////////////////////////////////////////////////////////////////////////////////
    a_start_one_cycle: assert property (!CYCLE_START_STROBE_N_O |=> CYCLE_START_STROBE_N_O)
        else $error("start strobe too long");
    a_read_both_lanes: assert property (!CYCLE_START_STROBE_N_O && RW_O && CTRL_OE_O |->
        !UPPER_BYTE_STROBE_N_O && !LOWER_BYTE_STROBE_N_O) else $error("read lanes");
    // With no completion for four cycles after a start, no new start may appear on the fourth.
    a_wait_complete: assert property (!CYCLE_START_STROBE_N_O ##1 CYCLE_COMPLETE_N_I [*4] |->
        CYCLE_START_STROBE_N_O) else $error("cycle ended early");
    a_hold_floats: assert property (!HOLD_ACKNOWLEDGE_N_O |-> !CTRL_OE_O && !ADDR_OE_O)
        else $error("driven in hold");
    a_hold_no_start: assert property (!HOLD_ACKNOWLEDGE_N_O |-> CYCLE_START_STROBE_N_O)
        else $error("start in hold");
    a_done_one_cycle: assert property (CYCLE_COMPLETE_OE_O && !CYCLE_COMPLETE_N_O |=> CYCLE_COMPLETE_N_O)
        else $error("completion too long");
    a_done_only_hold: assert property (CYCLE_COMPLETE_OE_O |-> !HOLD_ACKNOWLEDGE_N_O)
        else $error("completion outside hold");
    a_release_redrive: assert property ($rose(HOLD_ACKNOWLEDGE_N_O) |-> CTRL_OE_O && ADDR_OE_O)
        else $error("bus not redriven");
    a_burst_begins: assert property ($fell(BURST_N_O) |-> !CYCLE_START_STROBE_N_O)
        else $error("burst fall off start");
    a_burst_ends: assert property ($rose(BURST_N_O) |-> !CYCLE_START_STROBE_N_O)
        else $error("burst rise off start");
    c_burst: cover property ($fell(BURST_N_O));
    c_hold_done: cover property (CYCLE_COMPLETE_OE_O && !CYCLE_COMPLETE_N_O);
    c_release: cover property ($rose(HOLD_ACKNOWLEDGE_N_O));
endmodule
bind external_bus_interface_unit ebiu_sva u_sva (.*);

// ### ebiu_mem_model.sv
// External memory that ends each bus cycle after a set number of wait cycles.
`timescale 1ns/10ps
module ebiu_mem_model (
    input wire logic clk_i,
    input wire logic start_n_i,
    input wire logic rw_i,
    input wire logic [22:0] addr_i,
    input wire logic [2:0] wait_i,
    output logic complete_n_o,
    output logic [15:0] data_o
);
    logic busy_q = 1'b0;
    logic [2:0] cnt_q = 3'h0;
    initial complete_n_o = 1'b1;
    initial data_o = 16'h0;
    always @(posedge clk_i) begin
        complete_n_o <= 1'b1;
        if (!start_n_i) begin
            busy_q <= 1'b1;
            cnt_q <= wait_i;
        end else if (busy_q && cnt_q == 3'h0) begin
            busy_q <= 1'b0;
            complete_n_o <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    // Undriven lines toggle so a stale value never passes for fresh read data.
    always @(posedge clk_i) begin
        data_o <= rw_i ? ({addr_i[7:0], addr_i[15:8]} ^ 16'h5a3c) : ~data_o;
    end
endmodule

// ### external_bus_interface_unit_tb.sv
// Self-checking bench for the external bus interface unit.
`timescale 1ns/10ps
module external_bus_interface_unit_tb;
    typedef struct packed {
        logic [1:0] kind;
        logic wr;
        logic io;
        logic fetch;
        logic [1:0] lanes;
        logic [23:0] addr;
        logic [31:0] wdata;
        logic [2:0] wt;
    } row_s;
    logic REF_CLK_I = 1'b0, RESET_I = 1'b1, REQ_VALID_I = 1'b0, REQ_WRITE_I = 1'b0, REQ_IO_I = 1'b0;
    logic REQ_FETCH_I = 1'b0, HOLD_REQUEST_N_I = 1'b1, CHIP_SELECT_N_I = 1'b1, DRAM_ACK_I = 1'b0;
    logic [1:0] REQ_KIND_I = 2'h0, REQ_LANES_I = 2'h3;
    logic [23:0] REQ_ADDR_I = 24'h0;
    logic [31:0] REQ_WDATA_I = 32'h0;
    logic [22:0] ma = 23'h0;
    logic [3:0] mc = 4'hf;
    logic [2:0] wt = 3'h0;
    logic [127:0] DRAM_RDATA_I = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
    logic REQ_READY_O, RD_VALID_O, DONE_O, ADDR_OE_O, DATA_OE_O, SPACE_SELECT_O, RW_O, CYCLE_TYPE_O;
    logic UPPER_BYTE_STROBE_N_O, LOWER_BYTE_STROBE_N_O, CYCLE_START_STROBE_N_O, BURST_N_O, CTRL_OE_O;
    logic CYCLE_COMPLETE_N_O, CYCLE_COMPLETE_OE_O, HOLD_ACKNOWLEDGE_N_O, DRAM_REQ_O, DRAM_WE_O, mdone;
    logic SPACE_SELECT_I, UPPER_BYTE_STROBE_N_I, LOWER_BYTE_STROBE_N_I, RW_I, CYCLE_COMPLETE_N_I;
    logic [15:0] RD_DATA_O, DATA_O, DATA_I, DRAM_ADDR_O, md;
    logic [22:0] ADDR_O, ADDR_I;
    logic [127:0] DRAM_WDATA_O;
    int n_fail = 0, n_compared = 0, acks = 0;
    logic [44:0] beats[$];
    logic [15:0] rdq[$];
    row_s rows[6] = '{'{ebiu_pkg::KIND_SINGLE, 1'b0, 1'b0, 1'b1, 2'h2, 24'h100024, 32'h0, 3'h1},
        '{ebiu_pkg::KIND_SINGLE, 1'b1, 1'b1, 1'b0, 2'h1, 24'h200046, 32'h0000beef, 3'h0},
        '{ebiu_pkg::KIND_WORD, 1'b0, 1'b0, 1'b0, 2'h3, 24'h300088, 32'h0, 3'h2},
        '{ebiu_pkg::KIND_WORD, 1'b1, 1'b0, 1'b0, 2'h3, 24'h30008c, 32'hcafe1234, 3'h0},
        '{ebiu_pkg::KIND_LINE, 1'b0, 1'b0, 1'b1, 2'h3, 24'h400014, 32'h0, 3'h1},
        '{ebiu_pkg::KIND_RUN, 1'b0, 1'b0, 1'b1, 2'h3, 24'h40002c, 32'h0, 3'h0}};
    assign ADDR_I = ADDR_OE_O ? ADDR_O : ma;
    assign DATA_I = DATA_OE_O ? DATA_O : md;
    assign {SPACE_SELECT_I, UPPER_BYTE_STROBE_N_I, LOWER_BYTE_STROBE_N_I, RW_I} =
        CTRL_OE_O ? {SPACE_SELECT_O, UPPER_BYTE_STROBE_N_O, LOWER_BYTE_STROBE_N_O, RW_O} : mc;
    assign CYCLE_COMPLETE_N_I = CYCLE_COMPLETE_OE_O ? CYCLE_COMPLETE_N_O : mdone;
    external_bus_interface_unit u_dut (.*);
    ebiu_mem_model u_mem (.clk_i(REF_CLK_I), .start_n_i(CYCLE_START_STROBE_N_O), .rw_i(RW_O),
        .addr_i(ADDR_O), .wait_i(wt), .complete_n_o(mdone), .data_o(md));
    ////////////////////////////////////////////////////////////////////////////////
    always #4 REF_CLK_I = ~REF_CLK_I;
    always @(posedge REF_CLK_I) begin
        DRAM_ACK_I <= DRAM_REQ_O && !DRAM_ACK_I;
        if (DRAM_REQ_O && !DRAM_ACK_I)
            acks <= acks + 1;
    end
    always @(negedge REF_CLK_I) begin
        if (CYCLE_START_STROBE_N_O === 1'b0)
            beats.push_back({ADDR_O, RW_O, SPACE_SELECT_O, CYCLE_TYPE_O, UPPER_BYTE_STROBE_N_O,
                LOWER_BYTE_STROBE_N_O, BURST_N_O, DATA_O});
        if (RD_VALID_O === 1'b1)
            rdq.push_back(RD_DATA_O);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic tmo(input int k);
        chk(k < 200, "timeout");
        if (k >= 200)
            end_of_test();
    endtask
    task automatic run_row(input row_s r, input logic prev_rd);
        int k;
        int n;
        logic [22:0] a;
        logic [22:0] ea;
        logic single;
        a = r.addr[23:1];
        single = r.kind == ebiu_pkg::KIND_SINGLE;
        n = single ? 1 : r.kind == ebiu_pkg::KIND_WORD ? 2 : r.kind == ebiu_pkg::KIND_LINE ? 8 : 8 - a[2:0];
        beats.delete();
        rdq.delete();
        for (k = 0; k < 200 && REQ_READY_O !== 1'b1; k++) @(negedge REF_CLK_I);
        tmo(k);
        @(posedge REF_CLK_I);
        {REQ_KIND_I, REQ_WRITE_I, REQ_IO_I, REQ_FETCH_I, REQ_LANES_I, REQ_ADDR_I, REQ_WDATA_I, wt} <= r;
        REQ_VALID_I <= 1'b1;
        @(posedge REF_CLK_I);
        REQ_VALID_I <= 1'b0;
        for (k = 1; k < 200 && CYCLE_START_STROBE_N_O !== 1'b0; k++) @(negedge REF_CLK_I);
        chk(k == 2, "start delay");
        for (k = 0; k < 200 && DONE_O !== 1'b1; k++) @(negedge REF_CLK_I);
        tmo(k);
        @(posedge REF_CLK_I);
        chk(beats.size() == n && rdq.size() == (r.wr ? 0 : n), "beat count");
        for (k = 0; k < beats.size(); k++) begin
            ea = r.kind == ebiu_pkg::KIND_LINE ? {a[22:3], a[2:0] + 3'(k)} : a + 23'(k);
            chk(beats[k][44:16] === {ea, ~r.wr, r.io, ~r.fetch, (r.wr && single) ? ~r.lanes : 2'h0,
                1'(single || k == n - 1)}, "beat fields");
            if (r.wr)
                chk(beats[k][15:0] === (k == 0 && !single ? r.wdata[31:16] : r.wdata[15:0]), "wdata");
            else
                chk(rdq[k] === (({ea[7:0], ea[15:8]} ^ 16'h5a3c) & (single ? {{8{r.lanes[1]}},
                    {8{r.lanes[0]}}} : 16'hffff)), "rdata");
        end
    endtask
    task automatic hold_read(input logic [22:0] ad, input logic [15:0] e);
        int k;
        @(posedge REF_CLK_I);
        ma <= ad;
        @(negedge REF_CLK_I);
        for (k = 0; k < 200 && !(CYCLE_COMPLETE_OE_O === 1'b1 && CYCLE_COMPLETE_N_O === 1'b0); k++)
            @(negedge REF_CLK_I);
        tmo(k);
        chk(DATA_O === e && DATA_OE_O === 1'b1 && acks == 1, "hold read");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        logic prev_rd;
        prev_rd = 1'b0;
        repeat (4) @(posedge REF_CLK_I);
        RESET_I <= 1'b0;
        @(negedge REF_CLK_I);
        chk(REQ_READY_O === 1'b0 && CYCLE_START_STROBE_N_O === 1'b1 && DATA_OE_O === 1'b0, "reset");
        for (k = 0; k < 6; k++) begin
            run_row(rows[k], prev_rd);
            prev_rd = !rows[k].wr;
        end
        HOLD_REQUEST_N_I <= 1'b0;
        for (k = 0; k < 200 && HOLD_ACKNOWLEDGE_N_O !== 1'b0; k++) @(negedge REF_CLK_I);
        tmo(k);
        chk(CTRL_OE_O === 1'b0 && ADDR_OE_O === 1'b0, "hold float");
        @(posedge REF_CLK_I);
        mc <= 4'h1;
        ma <= 23'h12;
        CHIP_SELECT_N_I <= 1'b0;
        hold_read(23'h12, 16'h4455);
        hold_read(23'h15, 16'haabb);
        @(posedge REF_CLK_I);
        CHIP_SELECT_N_I <= 1'b1;
        mc <= 4'hf;
        @(posedge REF_CLK_I);
        HOLD_REQUEST_N_I <= 1'b1;
        for (k = 0; k < 200 && HOLD_ACKNOWLEDGE_N_O !== 1'b1; k++) @(negedge REF_CLK_I);
        tmo(k);
        chk(CTRL_OE_O === 1'b1 && ADDR_OE_O === 1'b1, "release");
        run_row(rows[0], 1'b0);
        end_of_test();
    end
endmodule
